/* design/sadw_decoder.sv */
`timescale 1ns/1ps
`include "sadw_params.svh"
module sadw_decoder
  import sadw_pkg::*;
#(
  parameter int DEPTH = 4,
  parameter logic [1:0] SRAM_MAX = `SADW_SRAM_96K
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire sadw_req_t cpuReq,
  input wire sadw_req_t dmaReq,
  input wire logic cpuBufEnable,
  input wire logic [1:0] sramSizeSel,
  input wire sadw_bank_t bankCfgPri,
  input wire sadw_bank_t bankCfgSec,
  input wire logic cfgWrite,
  input wire logic nvBootSecondary,
  input wire logic [1:0] flashBusy,
  input wire logic dstDone,
  input wire logic [31:0] dstRdata,
  output sadw_dst_t dstReq,
  output logic cpuReady,
  output logic dmaReady,
  output logic [31:0] rdata,
  output logic bufEnabled,
  output logic [31:0] sramBytes,
  output logic [1:0] bankEnable,
  output logic bootIsSecondary,
  output logic [2:0] fifoCount
);
  // pointers wrap at DEPTH, so DEPTH must be a power of two
  localparam int PW = $clog2(DEPTH);

  // every register of the block except the fifo word store lives in this
  // struct, so that reset and update stay in one place
  typedef struct packed {
    sadw_state_t state;
    logic        bufEn;
    logic [31:0] sramLen;
    sadw_bank_t  bankP;
    sadw_bank_t  bankS;
    logic        bootSec;
    logic        strapDone;
    logic [PW-1:0] wrPtr;
    logic [PW-1:0] rdPtr;
    logic [PW:0] count;
    logic        curCpu;
    sadw_dst_t   dst;
    logic        cpuRdy;
    logic        dmaRdy;
    logic [31:0] rdata;
  } sadw_state_s_t;

  sadw_state_s_t s;
  sadw_state_s_t next_s;
  // a fifo word holds the full cpu address and the data, so a drained
  // entry still knows its window and its target
  logic [63:0] fifoMem [DEPTH];
  logic fifoPush;
  logic [63:0] fifoIn;

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  // windows are 64 MB each; the top six address bits pick one
  // flat map: unmatched addresses fall to generic ahb target
  function automatic sadw_tgt_t tgtOf(input logic [31:0] a);
    logic [5:0] w;
    w = a[31:26];
    tgtOf = SADW_TGT_AHBP;
    if (w == 6'h00) tgtOf = SADW_TGT_FLASH;
    else if (w == `SADW_WIN_DTCM) tgtOf = SADW_TGT_DTCM;
    else if (w == `SADW_WIN_SRAM_BUF || w == `SADW_WIN_SRAM_NB)
      tgtOf = SADW_TGT_SRAM;
    else if (w == `SADW_WIN_FLASH_BUF || w == `SADW_WIN_FLASH_NB)
      tgtOf = SADW_TGT_FLASH;
    else if (w == `SADW_WIN_PERIPHERAL_BRIDGE_ZERO_BUF || w == `SADW_WIN_PERIPHERAL_BRIDGE_ZERO_NB)
      tgtOf = SADW_TGT_PERIPHERAL_BRIDGE_ZERO;
    else if (w == `SADW_WIN_PERIPHERAL_BRIDGE_ONE_BUF || w == `SADW_WIN_PERIPHERAL_BRIDGE_ONE_NB)
      tgtOf = SADW_TGT_PERIPHERAL_BRIDGE_ONE;
  endfunction

  // buffered alias windows, from 0x4000_0000 up to the peripheral_bridge_one buffered window
  // and the buffered high-speed ahb windows
  function automatic logic bufWin(input logic [31:0] a);
    logic [5:0] w;
    w = a[31:26];
    bufWin = (w >= `SADW_WIN_SRAM_BUF && w <= `SADW_WIN_PERIPHERAL_BRIDGE_ONE_BUF)
      || (w >= `SADW_WIN_BUF_LO && w <= `SADW_WIN_BUF_HI);
  endfunction

  // apb bridge base plus peripheral offset plus location offset
  // is kept as a byte offset within the 64 MB bridge window
  function automatic logic [31:0] localAddr(input logic [31:0] a);
    localAddr = {6'h00, a[25:0]};
  endfunction

  // flash bank of a flash access: boot bank owns zero until banks are set
  // a gap between configured banks falls back to the boot bank, so an
  // unset map still lands in flash
  function automatic logic bankOf(input logic [31:0] a,
                                  input sadw_bank_t p,
                                  input sadw_bank_t sc,
                                  input logic bs);
    logic [31:0] o;
    o = {6'h00, a[25:0]};
    if (sc.enable && o >= sc.start && o - sc.start < sc.size)
      bankOf = 1'b1;
    else if (p.enable && o >= p.start && o - p.start < p.size)
      bankOf = 1'b0;
    else
      bankOf = bs;
  endfunction

  function automatic logic [31:0] szBytes(input logic [1:0] c);
    case (c)
      `SADW_SRAM_64K: szBytes = `SADW_SRAM_64K_BYTES;
      `SADW_SRAM_96K: szBytes = `SADW_SRAM_96K_BYTES;
      default: szBytes = `SADW_SRAM_32K_BYTES;
    endcase
  endfunction

  // ------------------------------------------------------------
  // request classification
  // ------------------------------------------------------------
  logic cpuBuffered;
  logic fifoFull;
  logic rdHazard;
  logic [DEPTH-1:0] slotHit;

  // a read must not overtake a pending write to the same word; only the
  // offset is compared, which may wait needlessly across windows
  for (genvar g = 0; g < DEPTH; g++) begin : g_slot
    assign slotHit[g] = ((PW+1)'(g) < s.count)
      && (fifoMem[s.rdPtr + PW'(g)][57:34] == cpuReq.addr[25:2]);
  end

  always_comb begin
    cpuBuffered = cpuReq.write && s.bufEn
      && bufWin(cpuReq.addr);
    fifoFull = (s.count == (PW+1)'(DEPTH));
    rdHazard = |slotHit;
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  logic [63:0] head;
  sadw_tgt_t headTgt;
  logic headBank;
  // the oldest fifo entry drains only while its flash bank is free
  logic headBlocked;
  always_comb begin
    next_s = s;
    next_s.cpuRdy = 1'b0;
    next_s.dmaRdy = 1'b0;
    fifoPush = 1'b0;
    head = fifoMem[s.rdPtr];
    headTgt = tgtOf(head[63:32]);
    headBank = bankOf(head[63:32], s.bankP, s.bankS, s.bootSec);
    headBlocked = (headTgt == SADW_TGT_FLASH)
      && flashBusy[headBank];
    fifoIn = {cpuReq.addr, cpuReq.data};
    next_s.bufEn = cpuBufEnable;
    // size register only grows to what this variant supports; the boot
    // bank is forced on, as firmware runs from it while it sets the map
    if (cfgWrite) begin
      next_s.sramLen = szBytes((sramSizeSel > SRAM_MAX) ? SRAM_MAX
        : sramSizeSel);
      next_s.bankP = bankCfgPri;
      next_s.bankS = bankCfgSec;
      if (s.bootSec) next_s.bankS.enable = 1'b1;
      else next_s.bankP.enable = 1'b1;
    end
    // strap caught once after release; cpu has no path to it
    if (!s.strapDone) begin
      next_s.strapDone = 1'b1;
      next_s.bootSec = nvBootSecondary;
      next_s.bankP.enable = !nvBootSecondary;
      next_s.bankS.enable = nvBootSecondary;
    end
    // buffered cpu write: accept at once unless full; this runs beside
    // the state machine, so a drain in progress never stalls the cpu
    if (s.strapDone && cpuReq.valid && cpuBuffered && !s.cpuRdy
        && !(s.state == SADW_DIRECT && s.curCpu) && !fifoFull) begin
      fifoPush = 1'b1;
      next_s.wrPtr = s.wrPtr + 1'b1;
      next_s.cpuRdy = 1'b1;
    end
    // priority: cpu direct access, then fifo drain, then other masters;
    // a read held by a hazard lets the drain run so the hazard clears
    case (s.state)
      SADW_IDLE: begin
        next_s.dst.valid = 1'b0;
        if (!s.strapDone) begin
          next_s.state = SADW_IDLE;
        end else if (cpuReq.valid && !cpuBuffered && !s.cpuRdy
                     && !(cpuReq.write == 1'b0 && rdHazard)
                     && !(tgtOf(cpuReq.addr) == SADW_TGT_FLASH
                          && flashBusy[bankOf(cpuReq.addr, s.bankP,
                                              s.bankS, s.bootSec)])) begin
          // direct cpu access, reads included
          next_s.state = SADW_DIRECT;
          next_s.curCpu = 1'b1;
          next_s.dst = '{1'b1, tgtOf(cpuReq.addr),
                         bankOf(cpuReq.addr, s.bankP, s.bankS, s.bootSec),
                         cpuReq.write, localAddr(cpuReq.addr), cpuReq.data};
        end else if (s.count != '0 && !headBlocked) begin
          // the entry goes to the target of the window it was written to
          next_s.state = SADW_DRAIN;
          next_s.dst = '{1'b1, headTgt, headBank, 1'b1,
                         localAddr(head[63:32]), head[31:0]};
        end else if (dmaReq.valid && !s.dmaRdy) begin
          // other masters never buffer
          next_s.state = SADW_DIRECT;
          next_s.curCpu = 1'b0;
          next_s.dst = '{1'b1, tgtOf(dmaReq.addr),
                         bankOf(dmaReq.addr, s.bankP, s.bankS, s.bootSec),
                         dmaReq.write, localAddr(dmaReq.addr), dmaReq.data};
        end
      end
      SADW_DIRECT: begin
        // the answer is registered, so ready and read data appear together
        // one cycle after the far side completes
        if (dstDone) begin
          next_s.dst.valid = 1'b0;
          next_s.state = SADW_IDLE;
          next_s.rdata = dstRdata;
          if (s.curCpu) next_s.cpuRdy = 1'b1;
          else next_s.dmaRdy = 1'b1;
        end
      end
      SADW_DRAIN: begin
        if (dstDone) begin
          next_s.dst.valid = 1'b0;
          next_s.state = SADW_IDLE;
          next_s.rdPtr = s.rdPtr + 1'b1;
        end
      end
      default: next_s.state = SADW_IDLE;
    endcase
    next_s.count = s.count + {{PW{1'b0}}, fifoPush}
      - {{PW{1'b0}}, (s.state == SADW_DRAIN && dstDone)};
  end

  // fifo word store kept out of the reset state
  always_ff @(posedge clock) begin
    if (fifoPush) begin
      fifoMem[s.wrPtr] <= fifoIn;
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  // reset fields below override the all-zero fill; the strap is caught on
  // the first edge after release, so requests count from the second
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      s <= '0;
      s.state <= SADW_IDLE;
      s.bufEn <= 1'b0;
      s.sramLen <= `SADW_SRAM_32K_BYTES;
      s.bankP.size <= `SADW_BOOTSIZE_RST;
      s.bankS.size <= `SADW_BOOTSIZE_RST;
    end else begin
      s <= next_s;
    end
  end

  // every output is a register field or a fixed slice of one
  assign dstReq = s.dst;
  assign cpuReady = s.cpuRdy;
  assign dmaReady = s.dmaRdy;
  assign rdata = s.rdata;
  assign bufEnabled = s.bufEn;
  assign sramBytes = s.sramLen;
  assign bankEnable = {s.bankS.enable, s.bankP.enable};
  assign bootIsSecondary = s.bootSec;
  assign fifoCount = 3'(s.count);
endmodule

/* design/sadw_params.svh */
`ifndef SADW_PARAMS_SVH
`define SADW_PARAMS_SVH
// window bases (top six address bits select a 64 MB window)
`define SADW_WIN_DTCM 6'h01
`define SADW_WIN_SRAM_BUF 6'h10
`define SADW_WIN_FLASH_BUF 6'h11
`define SADW_WIN_PERIPHERAL_BRIDGE_ZERO_BUF 6'h12
`define SADW_WIN_PERIPHERAL_BRIDGE_ONE_BUF 6'h13
`define SADW_WIN_SRAM_NB 6'h14
`define SADW_WIN_FLASH_NB 6'h15
`define SADW_WIN_PERIPHERAL_BRIDGE_ZERO_NB 6'h16
`define SADW_WIN_PERIPHERAL_BRIDGE_ONE_NB 6'h17
`define SADW_WIN_BUF_LO 6'h18
`define SADW_WIN_BUF_HI 6'h1A
`define SADW_WIN_NB_LO 6'h1B
`define SADW_WIN_NB_HI 6'h1D
`define SADW_WIN_BUF_TOP 6'h1E
`define SADW_BOOT_ADDR 32'h0000_0000
`define SADW_BUFEN_BIT 3
// sram size codes
`define SADW_SRAM_32K 2'h0
`define SADW_SRAM_64K 2'h1
`define SADW_SRAM_96K 2'h2
`define SADW_SRAM_32K_BYTES 32'h0000_8000
`define SADW_SRAM_64K_BYTES 32'h0001_0000
`define SADW_SRAM_96K_BYTES 32'h0001_8000
`define SADW_BOOTSIZE_RST 32'h0001_0000
`endif

/* design/sadw_pkg.sv */
package sadw_pkg;
  typedef enum logic [3:0] {
    SADW_TGT_NONE  = 4'h0,
    SADW_TGT_FLASH = 4'h1,
    SADW_TGT_DTCM  = 4'h2,
    SADW_TGT_SRAM  = 4'h3,
    SADW_TGT_PERIPHERAL_BRIDGE_ZERO  = 4'h4,
    SADW_TGT_PERIPHERAL_BRIDGE_ONE  = 4'h5,
    SADW_TGT_AHBP  = 4'h6
  } sadw_tgt_t;

  typedef enum logic [2:0] {
    SADW_IDLE = 3'b001,
    SADW_DIRECT = 3'b010,
    SADW_DRAIN = 3'b100
  } sadw_state_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        fromCpu;
    logic [31:0] addr;
    logic [31:0] data;
  } sadw_req_t;

  typedef struct packed {
    logic        valid;
    sadw_tgt_t   target;
    logic        bankSel;
    logic        write;
    logic [31:0] addr;
    logic [31:0] data;
  } sadw_dst_t;

  typedef struct packed {
    logic [31:0] start;
    logic [31:0] size;
    logic        enable;
  } sadw_bank_t;
endpackage

/* verif/sadw_decoder_sva.sv */
`timescale 1ns/1ps
// ------
// decoder checker
// ------
module sadw_decoder_chk
  import sadw_pkg::*;
#(
  parameter int DEPTH = 4
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire sadw_req_t cpuReq,
  input wire sadw_req_t dmaReq,
  input wire logic cfgWrite,
  input wire logic [1:0] sramSizeSel,
  input wire logic nvBootSecondary,
  input wire logic [1:0] flashBusy,
  input wire logic dstDone,
  input wire logic [31:0] dstRdata,
  input wire sadw_dst_t dstReq,
  input wire logic cpuReady,
  input wire logic dmaReady,
  input wire logic [31:0] rdata,
  input wire logic bufEnabled,
  input wire logic [31:0] sramBytes,
  input wire logic [1:0] bankEnable,
  input wire logic bootIsSecondary,
  input wire logic [2:0] fifoCount
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  // a read launched with dma idle can only be the cpu's own
  property route(logic [5:0] w, sadw_tgt_t t);
    $rose(dstReq.valid) && !dstReq.write && !dmaReq.valid && cpuReq.valid
      && !cpuReq.write && cpuReq.addr[31:26] == w
      |-> dstReq.target == t && dstReq.addr == {6'h00, cpuReq.addr[25:0]};
  endproperty
  dtcm_path_a: assert property (route(6'h01, SADW_TGT_DTCM))
    else $error("dtcm route wrong");
  apb_sum_a: assert property (route(6'h17, SADW_TGT_PERIPHERAL_BRIDGE_ONE))
    else $error("apb address wrong");
  rst_vals_a: assert property (
    $fell(sys_rst) |-> sramBytes == 32'h0000_8000 && !bufEnabled)
    else $error("reset status wrong");
  size_sel_a: assert property (
    cfgWrite && sramSizeSel == 2'h2 |=> sramBytes == 32'h0001_8000)
    else $error("sram size not applied");
  boot_bank_a: assert property (
    $fell(sys_rst) |=> bankEnable == ($past(nvBootSecondary) ? 2'h2 : 2'h1))
    else $error("boot bank wrong");
  boot_keep_a: assert property (
    !$past(sys_rst) && !$past(sys_rst, 2) |-> $stable(bootIsSecondary))
    else $error("boot select moved");
  dma_direct_a: assert property (dmaReady |-> $past(dstDone))
    else $error("dma write buffered");
  nb_wait_a: assert property (
    cpuReady && cpuReq.write && cpuReq.addr[31:26] == 6'h14 |-> $past(dstDone))
    else $error("direct write released early");
  rd_direct_a: assert property (
    cpuReady && !cpuReq.write |-> $past(dstDone) && rdata == $past(dstRdata))
    else $error("read not direct");
  busy_bank_a: assert property (
    $rose(dstReq.valid) && dstReq.target == SADW_TGT_FLASH
      |-> !flashBusy[dstReq.bankSel]) else $error("busy bank used");
  nb_apb_a: assert property (
    cpuReady && cpuReq.write && cpuReq.addr[31:27] == 5'h0B
      |-> $past(dstDone)) else $error("apb write buffered");
  fifo_bound_a: assert property (fifoCount <= 3'(DEPTH))
    else $error("fifo overfilled");
  cover property (fifoCount == DEPTH);
  cover property (dmaReady);
  cover property ($fell(sys_rst) ##1 bootIsSecondary);
endmodule

bind sadw_decoder sadw_decoder_chk #(.DEPTH(DEPTH)) chk (.clock, .sys_rst,
  .cpuReq, .dmaReq, .cfgWrite, .sramSizeSel, .nvBootSecondary, .flashBusy,
  .dstDone, .dstRdata, .dstReq, .cpuReady, .dmaReady, .rdata, .bufEnabled,
  .sramBytes, .bankEnable, .bootIsSecondary, .fifoCount);

/* verif/sadw_decoder_tb_top.sv */
`timescale 1ns/1ps
// ------
// decoder bench
// ------
module sadw_decoder_tb_top
  import sadw_pkg::*;
;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  sadw_req_t cpuReq = '0;
  sadw_req_t dmaReq = '0;
  sadw_bank_t bankCfgPri = '0;
  sadw_bank_t bankCfgSec = '0;
  logic cpuBufEnable = 1'b0;
  logic cfgWrite = 1'b0;
  logic nvBootSecondary = 1'b0;
  logic [1:0] sramSizeSel = 2'h0;
  logic [1:0] flashBusy = 2'h0;
  logic [3:0] lat = 4'h0;
  logic [2:0] peak = 3'h0;
  sadw_dst_t dstReq;
  logic dstDone, cpuReady, dmaReady, bufEnabled, bootIsSecondary;
  logic [31:0] dstRdata, rdata, sramBytes, d;
  logic [1:0] bankEnable;
  logic [2:0] fifoCount;
  logic [31:0] shadow [logic [31:0]];
  logic [31:0] expQ [$];
  logic [5:0] ws [3] = '{6'h01, 6'h10, 6'h14};
  logic [5:0] pw [5] = '{6'h12, 6'h13, 6'h16, 6'h17, 6'h11};
  int failCount = 0;
  int checkCount = 0;
  int cyc = 0;

  sadw_decoder uut (.clock, .sys_rst, .cpuReq, .dmaReq, .cpuBufEnable,
    .sramSizeSel, .bankCfgPri, .bankCfgSec, .cfgWrite, .nvBootSecondary,
    .flashBusy, .dstDone, .dstRdata, .dstReq, .cpuReady, .dmaReady, .rdata,
    .bufEnabled, .sramBytes, .bankEnable, .bootIsSecondary, .fifoCount);
  sadw_dst_model far (.clock, .sys_rst, .dstReq, .lat, .dstDone, .dstRdata);

  always #25 clock = ~clock;

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checkCount++;
    if (g !== e) begin
      failCount++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic testDone();
    $display("checks %0d mismatches %0d", checkCount, failCount);
    if (failCount == 0 && checkCount > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // aliases of one location fold to a single shadow key
  function automatic logic [31:0] loc(input logic [31:0] a);
    logic [5:0] w;
    w = a[31:26];
    if (w == 6'h01 || w == 6'h14) w = 6'h10;
    else if (w > 6'h14 && w < 6'h18) w = w - 6'h04;
    return {w, a[25:0]};
  endfunction

  // one access by cpu (m=0) or dma (m=1), held until its ready pulse
  task automatic acc(input logic m, input logic w, input logic [31:0] a);
    int n;
    n = 0;
    d = $urandom;
    @(posedge clock);
    if (m) dmaReq <= '{1'b1, w, 1'b0, a, d};
    else cpuReq <= '{1'b1, w, 1'b1, a, d};
    if (w) shadow[loc(a)] = d;
    else expQ.push_back(shadow[loc(a)]);
    do begin
      @(posedge clock);
      n++;
    end while ((m ? dmaReady : cpuReady) !== 1'b1 && n < 300);
    if (m) dmaReq.valid <= 1'b0;
    else cpuReq.valid <= 1'b0;
    if (n == 300) chk("ready", 32'h1, 32'h0);
  endtask

  task automatic cfg(input logic [1:0] s);
    @(posedge clock);
    cfgWrite <= 1'b1;
    sramSizeSel <= s;
    bankCfgPri <= '{32'h0, 32'h1_0000, 1'b1};
    bankCfgSec <= '{32'h1_0000, 32'h8000, 1'b1};
    @(posedge clock);
    cfgWrite <= 1'b0;
    @(posedge clock);
  endtask

  // read results against the oldest note; also the hang limit
  always @(posedge clock) begin
    cyc++;
    if (fifoCount > peak) peak <= fifoCount;
    if (cpuReady === 1'b1 && cpuReq.write === 1'b0)
      chk("rdata", expQ.pop_front(), rdata);
    if (cyc == 20000) begin
      failCount++;
      testDone();
    end
  end

  initial begin
    d = $urandom(32'hAB77);
    repeat (16) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clock);
    chk("bankEnable", 32'h1, bankEnable);
    chk("sramBytes", 32'h8000, sramBytes);
    chk("bufEnabled", 32'h0, bufEnabled);
    acc(0, 1, 32'h0);
    acc(0, 0, 32'h0);
    cfg(2'h1);
    chk("sramBytes", 32'h1_0000, sramBytes);
    cfg(2'h2);
    chk("sramBytes", 32'h1_8000, sramBytes);
    chk("bankEnable", 32'h3, bankEnable);
    // buffering off: every alias must stay direct
    for (int i = 0; i < 16; i++) begin
      acc(0, 1, {ws[$urandom % 3], 26'(i * 4)});
      acc(0, 0, {ws[$urandom % 3], 26'(i * 4)});
    end
    foreach (pw[k]) begin
      acc(0, 1, {pw[k], 26'h1040});
      acc(0, 0, {pw[k], 26'h1040});
    end
    chk("fifoPeak", 32'h0, peak);
    cpuBufEnable <= 1'b1;
    acc(1, 1, 32'h4000_0200);
    acc(0, 0, 32'h5000_0200);
    chk("bufEnabled", 32'h1, bufEnabled);
    // buffered apb write must drain to its own bridge, not to sram
    acc(0, 1, {6'h12, 26'h2000});
    acc(0, 0, {6'h16, 26'h2000});
    acc(0, 1, {6'h17, 26'h2000});
    acc(0, 0, {6'h13, 26'h2000});
    // slow far side so buffered writes pile up to the fifo depth
    lat <= 4'h8;
    for (int i = 0; i < 6; i++) acc(0, 1, 32'h4000_0300 + i * 4);
    acc(0, 0, 32'h4000_0314);
    chk("fifoPeak", 32'h4, peak);
    lat <= 4'h0;
    flashBusy <= 2'b01;
    acc(0, 1, 32'h5401_0000);
    acc(0, 0, 32'h4401_0000);
    flashBusy <= 2'b00;
    cpuBufEnable <= 1'b0;
    nvBootSecondary <= 1'b1;
    sys_rst <= 1'b1;
    repeat (16) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clock);
    chk("bootSecondary", 32'h1, bootIsSecondary);
    chk("bankEnable", 32'h2, bankEnable);
    nvBootSecondary <= 1'b0;
    repeat (3) @(posedge clock);
    chk("bootSecondary", 32'h1, bootIsSecondary);
    testDone();
  end
endmodule

/* verif/sadw_dst_model.sv */
`timescale 1ns/1ps
// ------
// far side memory
// ------
module sadw_dst_model
  import sadw_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire sadw_dst_t dstReq,
  input wire logic [3:0] lat,
  output logic dstDone,
  output logic [31:0] dstRdata
);
  logic [31:0] mem [logic [35:0]];
  logic [35:0] key;
  logic [3:0] waitCnt;
  // tcm and ahb paths reach one sram array
  assign key = {dstReq.target == SADW_TGT_DTCM ? SADW_TGT_SRAM
    : dstReq.target, dstReq.addr};
  // data flips when idle so a stale word is never mistaken for an answer
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      dstDone <= 1'b0;
      dstRdata <= 32'h0;
      waitCnt <= 4'h0;
    end else if (dstReq.valid && !dstDone && waitCnt >= lat) begin
      dstDone <= 1'b1;
      waitCnt <= 4'h0;
      if (dstReq.write) begin
        mem[key] = dstReq.data;
      end
      dstRdata <= !dstReq.write && mem.exists(key) ? mem[key] : ~dstRdata;
    end else begin
      dstDone <= 1'b0;
      dstRdata <= ~dstRdata;
      waitCnt <= dstReq.valid && !dstDone ? waitCnt + 4'h1 : 4'h0;
    end
  end
endmodule
